// ===== hdl/sbi_pkg.sv
// Constants shared by the synthesizer bus interface
package sbi_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned CPU_CLK_HZ = 2000000;
   localparam int unsigned CPU_DIV = CLK_HZ / CPU_CLK_HZ;
   localparam int unsigned CPU_HIGH = CPU_DIV / 2;
   localparam int unsigned PWRUP_MS = 100;
   localparam int unsigned PWRUP_CYCLES = (CLK_HZ / 1000) * PWRUP_MS;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned FREQ_REGS = 6;
   // Upper decoder output assignment
   localparam int unsigned SEL_ROM1 = 0;
   localparam int unsigned SEL_LOWDEC = 1;
   localparam int unsigned SEL_RAM = 2;
   localparam int unsigned SEL_ROM2 = 3;
   // Address field positions
   localparam int unsigned UPPER_SEL_LSB = 12;
   localparam int unsigned UPPER_EN_BIT = 15;
   localparam int unsigned LOWER_EN_HIGH_BIT = 4;
   localparam int unsigned LOWER_EN_LOW_BIT = 5;
   localparam logic [7:0] FREQ_RESET = 8'h00;
   typedef enum {SBI_HOLD, SBI_RUN} sbi_rst_e;
endpackage

// ===== hdl/sbi_decoder.sv
// Three-to-eight decoder with one high and two low enables
`timescale 1ns/100ps
module sbi_decoder
(
   // Enables
   input wire logic decodeEnableHigh,
   input wire logic decodeEnableLowA_n,
   input wire logic decodeEnableLowB_n,
   // Select and outputs
   input wire logic [2:0] sel,
   output logic [7:0] yN
);
   always_comb
   begin
      yN = 8'hff;
      if (decodeEnableHigh && !decodeEnableLowA_n && !decodeEnableLowB_n)
      begin
         yN[sel] = 1'b0;
      end
   end
endmodule // sbi_decoder

// ===== hdl/sbi_top.sv
// Synthesizer bus interface: clock, reset, address latch, transceiver, decode, freq latches
// Functional notes
// - The CPU is clocked at 2 MHz.
// - CPU held in reset after power-up until supplies settle.
// - Transceiver drives toward CPU on read low, toward board otherwise.
// - Address strobe low captures both address bytes; held until next strobe.
// - Decoder drives one low output only when enabled.
// - Upper decoder uses A12-A15; outputs pick ROM1, lower decoder, RAM, ROM2.
// - Lower decoder uses A0-A2, A4, A5; outputs 0-5 strobe frequency latches.
// - The 2K RAM is selected only by its upper decoder chip enable.
// - Read strobe low reads RAM onto bus; write strobe low writes it.
// - Each ROM has its own chip enable; output enable follows read strobe.
// - Addressed latch strobe pulses low and loads the bus byte.
`timescale 1ns/100ps
module sbi_top
#(
   parameter int unsigned PWRUP_CYCLES = sbi_pkg::PWRUP_CYCLES,
   parameter int unsigned FREQ_REGS = sbi_pkg::FREQ_REGS
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Processor control
   output logic cpuClk,
   output logic cpuReset_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ale_n,
   // Processor buses
   input wire logic [7:0] upperAddressBus,
   input wire logic [7:0] muxedAddrDataIn,
   output logic [7:0] muxedAddrDataOut,
   output logic muxedAddrDataOe_n,
   // Board data bus
   input wire logic [7:0] boardDataIn,
   output logic [7:0] boardDataOut,
   output logic boardDataOe_n,
   output logic [15:0] latchedAddr,
   // Memory selects
   output logic ramCe_n,
   output logic ramOe_n,
   output logic ramWe_n,
   output logic rom1Ce_n,
   output logic rom2Ce_n,
   output logic romOe_n,
   // Synthesizer presets
   output logic [FREQ_REGS*8-1:0] freqPreset
);
   ////////////////////////////////////////////////////////////////////////////////
   // Processor clock divider and power-up reset
   logic [4:0] divCnt_r, divCnt_nxt;
   logic cpuClk_r, cpuClk_nxt;
   logic [31:0] pwrCnt_r, pwrCnt_nxt;
   sbi_pkg::sbi_rst_e rstState_r, rstState_nxt;
   logic [4:0] chkHigh_r, chkHigh_nxt;

   always_comb
   begin
      divCnt_nxt = (divCnt_r == 5'(sbi_pkg::CPU_DIV - 1)) ? 5'h00 : divCnt_r + 5'h01;
      cpuClk_nxt = (divCnt_nxt < 5'(sbi_pkg::CPU_HIGH));
      chkHigh_nxt = cpuClk_r ? chkHigh_r + 5'h01 : 5'h00;
      pwrCnt_nxt = pwrCnt_r;
      rstState_nxt = rstState_r;
      case (rstState_r)
         sbi_pkg::SBI_HOLD:
         begin
            // Supplies are assumed settled only after the whole count
            if (pwrCnt_r == PWRUP_CYCLES - 1)
            begin
               rstState_nxt = sbi_pkg::SBI_RUN;
            end
            else
            begin
               pwrCnt_nxt = pwrCnt_r + 32'h1;
            end
         end
         sbi_pkg::SBI_RUN:
         begin
            rstState_nxt = sbi_pkg::SBI_RUN;
         end
         default:
         begin
            rstState_nxt = sbi_pkg::SBI_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         divCnt_r <= 5'h00;
         cpuClk_r <= 1'b1;
         chkHigh_r <= 5'h00;
         pwrCnt_r <= 32'h0;
         rstState_r <= sbi_pkg::SBI_HOLD;
      end
      else
      begin
         divCnt_r <= divCnt_nxt;
         cpuClk_r <= cpuClk_nxt;
         chkHigh_r <= chkHigh_nxt;
         pwrCnt_r <= pwrCnt_nxt;
         rstState_r <= rstState_nxt;
      end
   end

   assign cpuClk = cpuClk_r;
   assign cpuReset_n = (rstState_r == sbi_pkg::SBI_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // Address latch and transceiver
   logic [15:0] addr_r, addr_nxt;
   logic ale_r, ale_nxt;
   logic [7:0] toCpu_r, toCpu_nxt;
   logic [7:0] toBoard_r, toBoard_nxt;

   always_comb
   begin
      ale_nxt = ale_n;
      addr_nxt = addr_r;
      // Capture on the falling edge only, so the byte holds through data phase
      if (ale_r && !ale_n)
      begin
         addr_nxt = {upperAddressBus, muxedAddrDataIn};
      end
      toCpu_nxt = boardDataIn;
      toBoard_nxt = muxedAddrDataIn;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ale_r <= 1'b1;
         addr_r <= 16'h0000;
         toCpu_r <= 8'h00;
         toBoard_r <= 8'h00;
      end
      else
      begin
         ale_r <= ale_nxt;
         addr_r <= addr_nxt;
         toCpu_r <= toCpu_nxt;
         toBoard_r <= toBoard_nxt;
      end
   end

   assign latchedAddr = addr_r;
   assign muxedAddrDataOut = toCpu_r;
   assign boardDataOut = toBoard_r;
   // One direction only; complementary enables never overlap
   assign muxedAddrDataOe_n = rd_n;
   assign boardDataOe_n = !rd_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode and memory selects
   logic [7:0] upperYN;
   logic [7:0] lowerYN;

   sbi_decoder u_upper
   (
      .decodeEnableHigh(1'b1),
      .decodeEnableLowA_n(addr_r[sbi_pkg::UPPER_EN_BIT]),
      .decodeEnableLowB_n(1'b0),
      .sel(addr_r[sbi_pkg::UPPER_SEL_LSB +: 3]),
      .yN(upperYN)
   );

   // Write strobe gates the lower decoder so strobes only pulse on writes
   sbi_decoder u_lower
   (
      .decodeEnableHigh(addr_r[sbi_pkg::LOWER_EN_HIGH_BIT]),
      .decodeEnableLowA_n(addr_r[sbi_pkg::LOWER_EN_LOW_BIT]),
      .decodeEnableLowB_n(upperYN[sbi_pkg::SEL_LOWDEC] | wr_n),
      .sel(addr_r[2:0]),
      .yN(lowerYN)
   );

   assign ramCe_n = upperYN[sbi_pkg::SEL_RAM];
   assign ramOe_n = rd_n;
   assign ramWe_n = wr_n;
   assign rom1Ce_n = upperYN[sbi_pkg::SEL_ROM1];
   assign rom2Ce_n = upperYN[sbi_pkg::SEL_ROM2];
   assign romOe_n = rd_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Frequency latches
   logic [FREQ_REGS-1:0] strobePrev_r, strobePrev_nxt;
   logic [7:0] busData_r, busData_nxt;
   logic [7:0] freq_r [FREQ_REGS];
   logic [7:0] freq_nxt [FREQ_REGS];

   always_comb
   begin
      strobePrev_nxt = lowerYN[FREQ_REGS-1:0];
      // Sampled while strobe is low; loaded on its rising edge like an edge flop
      busData_nxt = muxedAddrDataIn;
      for (int i = 0; i < FREQ_REGS; i++)
      begin
         freq_nxt[i] = freq_r[i];
         if (!strobePrev_r[i] && lowerYN[i])
         begin
            freq_nxt[i] = busData_r;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         strobePrev_r <= '1;
         busData_r <= 8'h00;
         for (int i = 0; i < FREQ_REGS; i++)
         begin
            freq_r[i] <= sbi_pkg::FREQ_RESET;
         end
      end
      else
      begin
         strobePrev_r <= strobePrev_nxt;
         busData_r <= busData_nxt;
         for (int i = 0; i < FREQ_REGS; i++)
         begin
            freq_r[i] <= freq_nxt[i];
         end
      end
   end

   always_comb
   begin
      for (int i = 0; i < FREQ_REGS; i++)
      begin
         freqPreset[i*8 +: 8] = freq_r[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_clk_high: assert property (@(posedge clk) disable iff (srst)
      (chkHigh_r <= 5'h0c) and ($fell(cpuClk) |-> chkHigh_r == 5'h0c))
      else $error("cpu clock high phase wrong");

   chk_clk_low: assert property (@(posedge clk) disable iff (srst)
      $fell(cpuClk) |-> !cpuClk [*8] ##1 !cpuClk [*5] ##1 cpuClk)
      else $error("cpu clock low phase wrong");

   chk_reset_release: assert property (@(posedge clk) disable iff (srst)
      $rose(cpuReset_n) |-> $past(pwrCnt_r) == PWRUP_CYCLES - 1)
      else $error("cpu reset released early");

   chk_reset_sticky: assert property (@(posedge clk) disable iff (srst)
      cpuReset_n |=> cpuReset_n)
      else $error("cpu reset reasserted");

   chk_xcvr_excl: assert property (@(posedge clk) disable iff (srst)
      (muxedAddrDataOe_n != boardDataOe_n) && (muxedAddrDataOe_n == rd_n))
      else $error("transceiver direction wrong");

   chk_addr_capture: assert property (@(posedge clk) disable iff (srst)
      (ale_r && !ale_n) |=> latchedAddr == {$past(upperAddressBus), $past(muxedAddrDataIn)})
      else $error("address not captured");

   chk_addr_hold: assert property (@(posedge clk) disable iff (srst)
      !(ale_r && !ale_n) |=> $stable(latchedAddr))
      else $error("address changed without strobe");

   chk_dec_onehot: assert property (@(posedge clk) disable iff (srst)
      $countones(~upperYN) == (latchedAddr[15] ? 0 : 1) && $countones(~lowerYN) <= 1)
      else $error("decoder not one-hot");

   chk_ram_select: assert property (@(posedge clk) disable iff (srst)
      !ramCe_n |-> latchedAddr[15:12] == 4'h2)
      else $error("ram selected at wrong address");

   chk_rom_select: assert property (@(posedge clk) disable iff (srst)
      (!rom1Ce_n |-> latchedAddr[15:12] == 4'h0) and (!rom2Ce_n |-> latchedAddr[15:12] == 4'h3))
      else $error("rom selected at wrong address");

   chk_strobe_write: assert property (@(posedge clk) disable iff (srst)
      (lowerYN != 8'hff) |-> (!wr_n && latchedAddr[15:12] == 4'h1))
      else $error("latch strobe without write");

   for (genvar g = 0; g < FREQ_REGS; g++)
   begin : g_chk
      chk_freq_load: assert property (@(posedge clk) disable iff (srst)
         (!strobePrev_r[g] && lowerYN[g]) |=> freqPreset[g*8 +: 8] == $past(busData_r))
         else $error("frequency latch not loaded");

      chk_freq_hold: assert property (@(posedge clk) disable iff (srst)
         !(!strobePrev_r[g] && lowerYN[g]) |=> $stable(freqPreset[g*8 +: 8]))
         else $error("frequency latch changed unstrobed");
   end
endmodule // sbi_top

// ===== sim/sbi_cpu_model.sv
// Processor-side bus model facing the synthesizer bus interface
`timescale 1ns/100ps
module sbi_cpu_model
(
   // Clock
   input wire logic clk,
   // Bus control
   output logic rd_n,
   output logic wr_n,
   output logic ale_n,
   // Buses
   output logic [7:0] upperAddressBus,
   output logic [7:0] muxedAddrDataIn,
   input wire logic [7:0] muxedAddrDataOut
);
   initial
   begin
      rd_n = 1'b1;
      wr_n = 1'b1;
      ale_n = 1'b1;
      upperAddressBus = 8'h00;
      muxedAddrDataIn = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Extra low cycles scramble the buses to show no recapture
   task automatic addrCycle(input logic [15:0] addr, input int lowCycles);
      @(negedge clk);
      upperAddressBus = addr[15:8];
      muxedAddrDataIn = addr[7:0];
      ale_n = 1'b0;
      for (int i = 1; i < lowCycles; i++)
      begin
         @(negedge clk);
         upperAddressBus = ~addr[15:8];
         muxedAddrDataIn = ~addr[7:0];
      end
      @(negedge clk);
      ale_n = 1'b1;
      // Released bus must not keep showing the address
      muxedAddrDataIn = ~muxedAddrDataIn;
   endtask
   task automatic writeData(input logic [7:0] data);
      @(negedge clk);
      muxedAddrDataIn = data;
      wr_n = 1'b0;
      @(negedge clk);
      wr_n = 1'b1;
      @(negedge clk);
      muxedAddrDataIn = ~data;
   endtask
   task automatic readData(output logic [7:0] data);
      @(negedge clk);
      rd_n = 1'b0;
      @(negedge clk);
      data = muxedAddrDataOut;
      @(negedge clk);
      rd_n = 1'b1;
   endtask
endmodule // sbi_cpu_model

// ===== sim/synth_bus_interface_bench.sv
// Self-checking bench for the synthesizer bus interface
`timescale 1ns/100ps
module synth_bus_interface_bench;
   localparam int PWR = 20;
   logic clk, srst, cpuClk, cpuReset_n, rd_n, wr_n, ale_n;
   logic [7:0] upperAddressBus, muxedAddrDataIn, muxedAddrDataOut, boardDataIn, boardDataOut;
   logic muxedAddrDataOe_n, boardDataOe_n, ramCe_n, ramOe_n, ramWe_n, rom1Ce_n, rom2Ce_n, romOe_n;
   logic [15:0] latchedAddr;
   logic [47:0] freqPreset;
   int mismatches, tests_run;
   sbi_top #(.PWRUP_CYCLES(PWR), .FREQ_REGS(6)) u_sbi_top (.clk(clk), .srst(srst),
      .cpuClk(cpuClk), .cpuReset_n(cpuReset_n), .rd_n(rd_n), .wr_n(wr_n), .ale_n(ale_n),
      .upperAddressBus(upperAddressBus), .muxedAddrDataIn(muxedAddrDataIn),
      .muxedAddrDataOut(muxedAddrDataOut), .muxedAddrDataOe_n(muxedAddrDataOe_n),
      .boardDataIn(boardDataIn), .boardDataOut(boardDataOut), .boardDataOe_n(boardDataOe_n),
      .latchedAddr(latchedAddr), .ramCe_n(ramCe_n), .ramOe_n(ramOe_n), .ramWe_n(ramWe_n),
      .rom1Ce_n(rom1Ce_n), .rom2Ce_n(rom2Ce_n), .romOe_n(romOe_n), .freqPreset(freqPreset));
   sbi_cpu_model u_sbi_cpu_model (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .ale_n(ale_n),
      .upperAddressBus(upperAddressBus), .muxedAddrDataIn(muxedAddrDataIn),
      .muxedAddrDataOut(muxedAddrDataOut));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic checkVec(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic testPowerUp;
      int n;
      n = 0;
      checkVec(48'(cpuReset_n), 48'h0);
      checkVec(freqPreset, 48'h0);
      srst = 1'b0;
      while (cpuReset_n !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      checkVec(48'(n), 48'(PWR));
      if (n >= 100)
         summarize;
   endtask
   task automatic testCpuClock;
      int hi, lo;
      hi = 0;
      lo = 0;
      for (int i = 0; i < 30 && cpuClk !== 1'b0; i++) @(negedge clk);
      for (int i = 0; i < 30 && cpuClk !== 1'b1; i++) @(negedge clk);
      while (cpuClk === 1'b1 && hi < 30)
      begin
         @(negedge clk);
         hi++;
      end
      while (cpuClk === 1'b0 && lo < 30)
      begin
         @(negedge clk);
         lo++;
      end
      checkVec({16'(hi), 16'(lo)}, {16'(sbi_pkg::CPU_HIGH), 16'(sbi_pkg::CPU_DIV - sbi_pkg::CPU_HIGH)});
   endtask
   task automatic testDecode;
      logic [15:0] a;
      for (int k = 0; k < 16; k++)
      begin
         a = {4'(k), 4'(~k), 4'(k), 4'(~k)};
         u_sbi_cpu_model.addrCycle(a, 1);
         @(negedge clk);
         checkVec(latchedAddr, a);
         checkVec({rom1Ce_n, ramCe_n, rom2Ce_n}, {k != 0, k != 2, k != 3});
      end
      u_sbi_cpu_model.addrCycle(16'h2345, 4);
      @(negedge clk);
      checkVec({latchedAddr, ramCe_n}, {16'h2345, 1'b0});
   endtask
   task automatic testTransceiver;
      logic [7:0] d;
      boardDataIn = 8'ha5;
      fork
         u_sbi_cpu_model.readData(d);
         begin
            repeat (2) @(negedge clk);
            checkVec({muxedAddrDataOe_n, boardDataOe_n, ramOe_n, romOe_n}, 4'h4);
         end
      join
      checkVec(d, 8'ha5);
      u_sbi_cpu_model.addrCycle(16'h2010, 1);
      fork
         u_sbi_cpu_model.writeData(8'h3c);
         begin
            @(negedge clk);
            @(posedge clk);
            #5;
            checkVec({muxedAddrDataOe_n, boardDataOe_n, ramWe_n, boardDataOut}, 11'h43c);
         end
      join
      checkVec(freqPreset, 48'h0);
   endtask
   task automatic testFreqLatches;
      logic [47:0] exp;
      logic [7:0] d;
      logic [15:0] bad [4];
      bad = '{16'h1030, 16'h1000, 16'h0010, 16'h9010};
      exp = 48'h0;
      for (int i = 0; i < 8; i++)
      begin
         d = {4'(i), 4'(9 - i)};
         u_sbi_cpu_model.addrCycle(16'h1010 | 16'(i), 1);
         u_sbi_cpu_model.writeData(d);
         @(negedge clk);
         if (i < 6)
            exp[8*i +: 8] = d;
         checkVec(freqPreset, exp);
      end
      foreach (bad[j])
      begin
         u_sbi_cpu_model.addrCycle(bad[j], 1);
         u_sbi_cpu_model.writeData(8'h99);
         @(negedge clk);
         checkVec(freqPreset, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      srst = 1'b1;
      boardDataIn = 8'h00;
      mismatches = 0;
      tests_run = 0;
      repeat (12) @(negedge clk);
      testPowerUp;
      testCpuClock;
      testDecode;
      testTransceiver;
      testFreqLatches;
      summarize;
   end
endmodule // synth_bus_interface_bench
